// *** tb/dtc_pin_model.sv ***
// pin model: gate pins and count inputs as the outside world drives them
// assumes the bench calls its tasks; pins change just after rising edges
`timescale 1ns/1ps
module dtc_pin_model (
    // clock
    input wire logic sys_clk,
    // pins
    output logic gate_pin_zero,
    output logic gate_pin_one,
    output logic count_input_pin0,
    output logic count_input_pin1
);
    initial {gate_pin_zero, gate_pin_one, count_input_pin0, count_input_pin1} = 4'h3;
    task automatic set_gates(input logic g0, input logic g1);
        @(posedge sys_clk);
        gate_pin_zero <= g0;
        gate_pin_one <= g1;
    endtask
    // each level held 4 cycles so the two-stage synchroniser never misses an edge
    task automatic pulse(input logic ch, input logic [3:0] n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge sys_clk);
            if (ch) count_input_pin1 <= 1'b0;
            else count_input_pin0 <= 1'b0;
            repeat (4) @(posedge sys_clk);
            if (ch) count_input_pin1 <= 1'b1;
            else count_input_pin0 <= 1'b1;
        end
    endtask
endmodule

// *** tb/dtc_timer_assertions.sv ***
// checker: bus handshake and overflow flag relations of the timer block
// assumes binding to dtc_timer_top; sees its ports only
`timescale 1ns/1ps
module dtc_timer_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // flags
    input wire logic timer0_service_ack,
    input wire logic timer1_service_ack,
    input wire logic timer0_overflow_flag,
    input wire logic timer1_overflow_flag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before bready");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before rready");
    AST_RDATA_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write response late");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
    AST_UNMAPPED_READ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0000_0238
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000))
        else $error("unmapped read not refused");
    AST_BUSY_READY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("ready high while write response pending");
    AST_FLAG0_FALL: assert property ($fell(timer0_overflow_flag) |-> $past(timer0_service_ack) || s_axi_bvalid)
        else $error("timer 0 flag cleared without cause");
    AST_FLAG1_FALL: assert property ($fell(timer1_overflow_flag) |-> $past(timer1_service_ack) || s_axi_bvalid)
        else $error("timer 1 flag cleared without cause");
endmodule

bind dtc_timer_top dtc_timer_checker u_dtc_timer_checker (
    .sys_clk(sys_clk), .resetn(resetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer0_service_ack(timer0_service_ack), .timer1_service_ack(timer1_service_ack),
    .timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag)
);

// *** tb/test_dual_timer_counter_mode_control.sv ***
// testbench of the dual timer/counter: bus master, pin model, row table, corner cases
// assumes the checker binds itself; internal tick every cycle for a short run
`timescale 1ns/1ps
module test_dual_timer_counter_mode_control;
    localparam logic [31:0] A_CTL = 32'h0000_0220;
    localparam logic [31:0] A_MODE = 32'h0000_0224;
    localparam logic [31:0] A_LO0 = 32'h0000_0228;
    localparam logic [31:0] A_LO1 = 32'h0000_022c;
    localparam logic [31:0] A_HI0 = 32'h0000_0230;
    localparam logic [31:0] A_HI1 = 32'h0000_0234;
    localparam logic [31:0] A_BAD = 32'h0000_0238;
    typedef struct packed {
        logic t; logic g; logic [7:0] mode; logic [7:0] lo; logic [7:0] hi;
        logic [3:0] n; logic [7:0] elo; logic [7:0] ehi; logic [7:0] ectl;
    } dtc_row_t;
    // timer, gate level, mode, low, high, falling edges, expected low, high, control
    dtc_row_t rows [12] = '{
        '{1'b0, 1'b0, 8'h05, 8'hff, 8'h12, 4'h1, 8'h00, 8'h13, 8'h10},
        '{1'b0, 1'b0, 8'h05, 8'hff, 8'hff, 4'h1, 8'h00, 8'h00, 8'h30},
        '{1'b0, 1'b0, 8'h04, 8'h1f, 8'h05, 4'h1, 8'h00, 8'h06, 8'h10},
        '{1'b0, 1'b0, 8'h04, 8'hff, 8'hff, 4'h1, 8'he0, 8'h00, 8'h30},
        '{1'b0, 1'b0, 8'h06, 8'hfe, 8'ha5, 4'h2, 8'ha5, 8'ha5, 8'h30},
        '{1'b0, 1'b0, 8'h07, 8'hff, 8'h33, 4'h1, 8'h00, 8'h33, 8'h30},
        '{1'b0, 1'b0, 8'h0d, 8'h10, 8'h00, 4'h3, 8'h10, 8'h00, 8'h10},
        '{1'b0, 1'b1, 8'h0d, 8'h10, 8'h00, 4'h3, 8'h13, 8'h00, 8'h10},
        '{1'b1, 1'b0, 8'h50, 8'hff, 8'h07, 4'h1, 8'h00, 8'h08, 8'h40},
        '{1'b1, 1'b0, 8'h70, 8'h11, 8'h22, 4'h2, 8'h11, 8'h22, 8'h40},
        '{1'b1, 1'b0, 8'hd0, 8'h05, 8'h00, 4'h2, 8'h05, 8'h00, 8'h40},
        '{1'b1, 1'b1, 8'hd0, 8'hff, 8'hff, 4'h2, 8'h01, 8'h00, 8'hc0}
    };
    localparam logic [31:0] ADDRS [6] = '{A_CTL, A_MODE, A_LO0, A_LO1, A_HI0, A_HI1};
    logic sys_clk, resetn;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, last_data;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
    logic gate_pin_zero, gate_pin_one, count_input_pin0, count_input_pin1;
    logic timer0_service_ack, timer1_service_ack, timer0_overflow_flag, timer1_overflow_flag;
    logic [7:0] hold;
    int errors = 0;
    int compares = 0;

    dtc_timer_top #(.TICK_DIV(1)) u_dtc_timer_top (
        .sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .gate_pin_zero(gate_pin_zero), .gate_pin_one(gate_pin_one), .count_input_pin0(count_input_pin0),
        .count_input_pin1(count_input_pin1), .timer0_service_ack(timer0_service_ack),
        .timer1_service_ack(timer1_service_ack), .timer0_overflow_flag(timer0_overflow_flag),
        .timer1_overflow_flag(timer1_overflow_flag)
    );
    dtc_pin_model u_dtc_pin_model (
        .sys_clk(sys_clk), .gate_pin_zero(gate_pin_zero), .gate_pin_one(gate_pin_one),
        .count_input_pin0(count_input_pin0), .count_input_pin1(count_input_pin1)
    );

    task automatic stop_test();
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk2(input string n, input logic [1:0] e, input logic [1:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (int i = 0; i < 200; i++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                last_resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        errors++;
        stop_test();
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (int i = 0; i < 200; i++) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                last_data = s_axi_rdata;
                last_resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        errors++;
        stop_test();
    endtask
    task automatic do_row(input dtc_row_t r);
        wr(A_CTL, 8'h00, 4'hf);
        u_dtc_pin_model.set_gates(r.g, r.g);
        wr(A_MODE, r.mode, 4'hf);
        wr(r.t ? A_LO1 : A_LO0, r.lo, 4'hf);
        wr(r.t ? A_HI1 : A_HI0, r.hi, 4'hf);
        wr(A_CTL, r.t ? 8'h40 : 8'h10, 4'hf);
        u_dtc_pin_model.pulse(r.t, r.n);
        repeat (8) @(posedge sys_clk);
        rd(A_CTL);
        chk8("control", r.ectl, last_data[7:0]);
        chk2("flags", {r.ectl[7], r.ectl[5]}, {timer1_overflow_flag, timer0_overflow_flag});
        wr(A_CTL, 8'h00, 4'hf);
        rd(r.t ? A_LO1 : A_LO0);
        chk8("count_low", r.elo, last_data[7:0]);
        rd(r.t ? A_HI1 : A_HI0);
        chk8("count_high", r.ehi, last_data[7:0]);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
        {timer0_service_ack, timer1_service_ack} = 2'b00;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            do_row(rows[i]);
        end
        // split high byte runs on timer 1 run bit
        wr(A_MODE, 8'h03, 4'hf);
        wr(A_LO0, 8'h00, 4'hf);
        wr(A_HI0, 8'h00, 4'hf);
        wr(A_CTL, 8'h40, 4'hf);
        repeat (20) @(posedge sys_clk);
        wr(A_CTL, 8'h00, 4'hf);
        rd(A_HI0);
        hold = last_data[7:0];
        chk2("split_high_moved", 2'b01, {1'b0, hold != 8'h00});
        rd(A_LO0);
        chk8("split_low_idle", 8'h00, last_data[7:0]);
        repeat (10) @(posedge sys_clk);
        rd(A_HI0);
        chk8("stopped_high", hold, last_data[7:0]);
        for (int k = 0; k < 2; k++) begin
            wr(A_CTL, k ? 8'h80 : 8'h20, 4'hf);
            @(negedge sys_clk);
            chk2("flag_set", k ? 2'b10 : 2'b01, {timer1_overflow_flag, timer0_overflow_flag});
            @(posedge sys_clk);
            timer0_service_ack <= (k == 0);
            timer1_service_ack <= (k == 1);
            @(posedge sys_clk);
            timer0_service_ack <= 1'b0;
            timer1_service_ack <= 1'b0;
            @(negedge sys_clk);
            chk2("flag_cleared", 2'b00, {timer1_overflow_flag, timer0_overflow_flag});
        end
        // mid-run reset clears all registers
        wr(A_HI0, 8'h5a, 4'hf);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        foreach (ADDRS[j]) begin
            rd(ADDRS[j]);
            chk8("reset_value", 8'h00, last_data[7:0]);
        end
        wr(A_MODE, 8'hff, 4'h0);
        chk2("strobe_resp", 2'b00, last_resp);
        rd(A_MODE);
        chk8("strobe_ignored", 8'h00, last_data[7:0]);
        wr(A_BAD, 8'h55, 4'hf);
        chk2("bad_write_resp", 2'b10, last_resp);
        rd(A_BAD);
        chk2("bad_read_resp", 2'b10, last_resp);
        chk8("bad_read_data", 8'h00, last_data[7:0]);
        stop_test();
    end
endmodule

// *** verilog/dtc_edge_sync.sv ***
// two-stage synchroniser with falling-edge pulse for an external pin
// assumes pin is asynchronous to sys_clk
`timescale 1ns/1ps
module dtc_edge_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // pin and outputs
    input wire logic pin,
    output logic level,
    output logic fall
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign fall = prev_reg & ~sync_reg;
endmodule

// *** verilog/dtc_params.svh ***
// constants of the dual timer/counter block: register offsets, field positions, timing
// assumes inclusion by bare name from the design files of this block
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

`define DTC_A_MODE 8'h89
`define DTC_A_LO0 8'h8a
`define DTC_A_LO1 8'h8b
`define DTC_A_HI0 8'h8c
`define DTC_A_HI1 8'h8d
`define DTC_A_CTL 8'h88

`define DTC_GATE1 7
`define DTC_SRC1 6
`define DTC_MODE1_HI 5
`define DTC_MODE1_LO 4
`define DTC_GATE0 3
`define DTC_SRC0 2
`define DTC_MODE0_HI 1
`define DTC_MODE0_LO 0

`define DTC_FLAG1 7
`define DTC_RUN1 6
`define DTC_FLAG0 5
`define DTC_RUN0 4

`define DTC_RESET_BYTE 8'h00
`define DTC_TICK_DIV 12

`endif

// *** verilog/dtc_pkg.sv ***
// types of the dual timer/counter block
// assumes the params header holds all numeric constants
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_MODE_PRESCALE = 2'b00,
        DTC_MODE_FULL16 = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_t;

    typedef enum logic [2:0] {
        DTC_BUS_IDLE = 3'b001,
        DTC_BUS_WRESP = 3'b010,
        DTC_BUS_RRESP = 3'b100
    } dtc_bus_state_t;
endpackage

// *** verilog/dtc_tick_div.sv ***
// divider making a one-cycle internal count tick
// assumes a single sys_clk domain
`timescale 1ns/1ps
module dtc_tick_div #(
    parameter int DIV = 12
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // tick
    output logic tick
);
    if (DIV < 1 || DIV > 65535) begin : g_div_check
        $error("tick divider out of range");
    end

    logic [15:0] cnt_reg;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cnt_reg <= 16'h0000;
        end else if (cnt_reg == 16'(DIV - 1)) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    assign tick = (cnt_reg == 16'(DIV - 1));
endmodule

// *** verilog/dtc_timer_top.sv ***
// dual 8-bit-pair timer/counter with mode register, AXI4-Lite register access
// assumes pins are asynchronous and an interrupt controller pulses service acknowledges
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "dtc_params.svh"
module dtc_timer_top #(
    parameter int TICK_DIV = `DTC_TICK_DIV
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external pins
    input wire logic gate_pin_zero,
    input wire logic gate_pin_one,
    input wire logic count_input_pin0,
    input wire logic count_input_pin1,
    // service entry acknowledges and flags
    input wire logic timer0_service_ack,
    input wire logic timer1_service_ack,
    output logic timer0_overflow_flag,
    output logic timer1_overflow_flag
);
    logic [7:0] timer_mode_control_reg;
    logic [7:0] timer0_count_low_reg;
    logic [7:0] timer0_count_high_reg;
    logic [7:0] timer1_count_low_reg;
    logic [7:0] timer1_count_high_reg;
    logic timer0_run_reg;
    logic timer1_run_reg;
    logic timer0_flag_reg;
    logic timer1_flag_reg;

    logic tick;
    logic gate0_lvl;
    logic gate1_lvl;
    logic cnt0_fall;
    logic cnt1_fall;

    dtc_tick_div #(.DIV(TICK_DIV)) u_dtc_tick_div (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick(tick)
    );

    dtc_edge_sync u_gate0 (.sys_clk(sys_clk), .resetn(resetn), .pin(gate_pin_zero), .level(gate0_lvl), .fall());
    dtc_edge_sync u_gate1 (.sys_clk(sys_clk), .resetn(resetn), .pin(gate_pin_one), .level(gate1_lvl), .fall());
    dtc_edge_sync u_cnt0 (.sys_clk(sys_clk), .resetn(resetn), .pin(count_input_pin0), .level(), .fall(cnt0_fall));
    dtc_edge_sync u_cnt1 (.sys_clk(sys_clk), .resetn(resetn), .pin(count_input_pin1), .level(), .fall(cnt1_fall));

    // ---- bus slave ----
    dtc_pkg::dtc_bus_state_t bus_state_reg;
    logic [31:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic [1:0] bresp_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic wr_fire;
    logic [7:0] wr_byte;
    logic wr_ok;

    function automatic logic addr_known(input logic [31:0] a);
        addr_known = (a[31:10] == 22'h0) && (a[9:2] inside {`DTC_A_CTL, `DTC_A_MODE, `DTC_A_LO0, `DTC_A_LO1,
            `DTC_A_HI0, `DTC_A_HI1});
    endfunction

    function automatic logic wr_hit(input logic [31:0] a, input logic [7:0] idx);
        wr_hit = (a[31:10] == 22'h0) && (a[9:2] == idx);
    endfunction

    assign s_axi_awready = (bus_state_reg == dtc_pkg::DTC_BUS_IDLE) && !aw_held_reg;
    assign s_axi_wready = (bus_state_reg == dtc_pkg::DTC_BUS_IDLE) && !w_held_reg;
    assign s_axi_arready = (bus_state_reg == dtc_pkg::DTC_BUS_IDLE) && !(aw_held_reg && w_held_reg);
    assign s_axi_bvalid = (bus_state_reg == dtc_pkg::DTC_BUS_WRESP);
    assign s_axi_rvalid = (bus_state_reg == dtc_pkg::DTC_BUS_RRESP);
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    assign wr_fire = (bus_state_reg == dtc_pkg::DTC_BUS_IDLE) && aw_held_reg && w_held_reg;
    assign wr_ok = wr_fire && addr_known(awaddr_reg) && wstrb_reg[0];
    assign wr_byte = wdata_reg[7:0];

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // write has priority over a read arriving in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            bus_state_reg <= dtc_pkg::DTC_BUS_IDLE;
            bresp_reg <= 2'b00;
            rresp_reg <= 2'b00;
            rdata_reg <= 32'h0000_0000;
        end else begin
            case (bus_state_reg)
                dtc_pkg::DTC_BUS_IDLE: begin
                    if (wr_fire) begin
                        bresp_reg <= addr_known(awaddr_reg) ? 2'b00 : 2'b10;
                        bus_state_reg <= dtc_pkg::DTC_BUS_WRESP;
                    end else if (s_axi_arvalid && s_axi_arready) begin
                        rresp_reg <= addr_known(s_axi_araddr) ? 2'b00 : 2'b10;
                        rdata_reg <= {24'h00_0000, read_mux(s_axi_araddr)};
                        bus_state_reg <= dtc_pkg::DTC_BUS_RRESP;
                    end
                end
                dtc_pkg::DTC_BUS_WRESP: begin
                    if (s_axi_bready) begin
                        bus_state_reg <= dtc_pkg::DTC_BUS_IDLE;
                    end
                end
                dtc_pkg::DTC_BUS_RRESP: begin
                    if (s_axi_rready) begin
                        bus_state_reg <= dtc_pkg::DTC_BUS_IDLE;
                    end
                end
                default: begin
                    bus_state_reg <= dtc_pkg::DTC_BUS_IDLE;
                end
            endcase
        end
    end

    function automatic logic [7:0] read_mux(input logic [31:0] a);
        read_mux = 8'h00;
        if (a[31:10] == 22'h0) begin
            case (a[9:2])
                `DTC_A_CTL: read_mux = {timer1_flag_reg, timer1_run_reg, timer0_flag_reg, timer0_run_reg, 4'h0};
                `DTC_A_MODE: read_mux = timer_mode_control_reg;
                `DTC_A_LO0: read_mux = timer0_count_low_reg;
                `DTC_A_LO1: read_mux = timer1_count_low_reg;
                `DTC_A_HI0: read_mux = timer0_count_high_reg;
                `DTC_A_HI1: read_mux = timer1_count_high_reg;
                default: read_mux = 8'h00;
            endcase
        end
    endfunction

    // ---- timer control decode ----
    dtc_pkg::dtc_mode_t mode0;
    dtc_pkg::dtc_mode_t mode1;
    logic en0;
    logic en1;
    logic step0;
    logic step1;
    logic step0h;

    assign mode0 = dtc_pkg::dtc_mode_t'({timer_mode_control_reg[`DTC_MODE0_HI],
        timer_mode_control_reg[`DTC_MODE0_LO]});
    assign mode1 = dtc_pkg::dtc_mode_t'({timer_mode_control_reg[`DTC_MODE1_HI],
        timer_mode_control_reg[`DTC_MODE1_LO]});

    // gate pin matters only while the gating bit is set
    assign en0 = timer0_run_reg && (!timer_mode_control_reg[`DTC_GATE0] || gate0_lvl);
    assign en1 = timer1_run_reg && (!timer_mode_control_reg[`DTC_GATE1] || gate1_lvl);
    assign step0 = en0 && (timer_mode_control_reg[`DTC_SRC0] ? cnt0_fall : tick);
    assign step1 = en1 && (timer_mode_control_reg[`DTC_SRC1] ? cnt1_fall : tick) &&
        (mode1 != dtc_pkg::DTC_MODE_SPLIT);
    // split high byte: timer only, run bit one, no gate
    assign step0h = timer1_run_reg && tick;

    // next count of a timer pair; returns overflow in bit 16
    function automatic logic [16:0] next_count(input dtc_pkg::dtc_mode_t m, input logic [7:0] lo,
        input logic [7:0] hi);
        logic [5:0] p;
        logic [8:0] h;
        logic [8:0] l;
        logic [16:0] w;
        p = {1'b0, lo[4:0]} + 6'h01;
        h = {1'b0, hi} + 9'h001;
        l = {1'b0, lo} + 9'h001;
        w = {1'b0, hi, lo} + 17'h0_0001;
        case (m)
            dtc_pkg::DTC_MODE_PRESCALE: begin
                // upper three low-byte bits are left untouched
                if (p[5]) begin
                    next_count = {h[8], h[7:0], lo[7:5], 5'h00};
                end else begin
                    next_count = {1'b0, hi, lo[7:5], p[4:0]};
                end
            end
            dtc_pkg::DTC_MODE_FULL16: next_count = w;
            dtc_pkg::DTC_MODE_RELOAD: next_count = {l[8], hi, (l[8] ? hi : l[7:0])};
            default: next_count = {l[8], hi, l[7:0]};
        endcase
    endfunction

    logic [16:0] nx0;
    logic [16:0] nx1;
    logic [8:0] nx0h;
    logic ovf0;
    logic ovf1;

    assign nx0 = next_count(mode0, timer0_count_low_reg, timer0_count_high_reg);
    assign nx1 = next_count(mode1, timer1_count_low_reg, timer1_count_high_reg);
    assign nx0h = {1'b0, timer0_count_high_reg} + 9'h001;
    assign ovf0 = step0 && nx0[16];
    assign ovf1 = (mode0 == dtc_pkg::DTC_MODE_SPLIT) ? (step0h && nx0h[8]) : (step1 && nx1[16]);

    // ---- register state ----
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            timer_mode_control_reg <= `DTC_RESET_BYTE;
        end else if (wr_ok && wr_hit(awaddr_reg, `DTC_A_MODE)) begin
            timer_mode_control_reg <= wr_byte;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            timer0_count_low_reg <= `DTC_RESET_BYTE;
            timer0_count_high_reg <= `DTC_RESET_BYTE;
        end else begin
            // software write to a byte wins over counting in that cycle
            if (wr_ok && wr_hit(awaddr_reg, `DTC_A_LO0)) begin
                timer0_count_low_reg <= wr_byte;
            end else if (step0) begin
                timer0_count_low_reg <= nx0[7:0];
            end
            if (wr_ok && wr_hit(awaddr_reg, `DTC_A_HI0)) begin
                timer0_count_high_reg <= wr_byte;
            end else if (mode0 == dtc_pkg::DTC_MODE_SPLIT) begin
                if (step0h) begin
                    timer0_count_high_reg <= nx0h[7:0];
                end
            end else if (step0) begin
                timer0_count_high_reg <= nx0[15:8];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            timer1_count_low_reg <= `DTC_RESET_BYTE;
            timer1_count_high_reg <= `DTC_RESET_BYTE;
        end else begin
            if (wr_ok && wr_hit(awaddr_reg, `DTC_A_LO1)) begin
                timer1_count_low_reg <= wr_byte;
            end else if (step1) begin
                timer1_count_low_reg <= nx1[7:0];
            end
            if (wr_ok && wr_hit(awaddr_reg, `DTC_A_HI1)) begin
                timer1_count_high_reg <= wr_byte;
            end else if (step1) begin
                timer1_count_high_reg <= nx1[15:8];
            end
        end
    end

    // run bits and flags; a hardware set wins over any clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            timer0_run_reg <= 1'b0;
            timer1_run_reg <= 1'b0;
            timer0_flag_reg <= 1'b0;
            timer1_flag_reg <= 1'b0;
        end else begin
            if (wr_ok && wr_hit(awaddr_reg, `DTC_A_CTL)) begin
                timer0_run_reg <= wr_byte[`DTC_RUN0];
                timer1_run_reg <= wr_byte[`DTC_RUN1];
            end
            if (ovf0) begin
                timer0_flag_reg <= 1'b1;
            end else if (wr_ok && wr_hit(awaddr_reg, `DTC_A_CTL)) begin
                timer0_flag_reg <= wr_byte[`DTC_FLAG0];
            end else if (timer0_service_ack) begin
                timer0_flag_reg <= 1'b0;
            end
            if (ovf1) begin
                timer1_flag_reg <= 1'b1;
            end else if (wr_ok && wr_hit(awaddr_reg, `DTC_A_CTL)) begin
                timer1_flag_reg <= wr_byte[`DTC_FLAG1];
            end else if (timer1_service_ack) begin
                timer1_flag_reg <= 1'b0;
            end
        end
    end

    assign timer0_overflow_flag = timer0_flag_reg;
    assign timer1_overflow_flag = timer1_flag_reg;
endmodule
